// ==== core/cpu_register_model.sv ====
// Architectural register set of the core with an AXI4-Lite debug view
//
// Function
// - User mode: sixteen 32-bit general registers, 32-bit program counter, 8-bit flag byte.
// - Data registers accept byte, word and long-word operations.
// - Pointer registers and user stack pointer serve as stack pointers and base registers.
// - Pointer registers accept word and long-word operations only.
// - Any of the sixteen registers can be the index register.
// - Two privilege levels; some operations allowed only in supervisor level.
// - Supervisor level adds status high byte and a separate privileged stack pointer.
// - Status word holds a three-bit interrupt mask of eight levels.
// - Status word holds overflow, zero, negative, carry and extend flags.
// - Status word holds a trace bit and a supervisor-state bit.
// - Status bits 5, 6, 7, 11, 12 and 14 are reserved.
// - Byte or word writes to a data register leave its upper bits unchanged.
// - Word writes to a pointer register are sign-extended and fill it.
`timescale 1ns/100ps
`default_nettype none
module cpu_register_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic coreWrEn,
  input wire logic [3:0] coreWrSel,
  input wire logic [1:0] coreWrSize,
  input wire logic [31:0] coreWrData,
  input wire logic [3:0] coreRdSel,
  input wire logic [1:0] coreRdSize,
  output logic [31:0] coreRdData,
  input wire logic [3:0] idxSel,
  input wire logic idxLong,
  output logic [31:0] idxData,
  input wire logic pcLoad,
  input wire logic [31:0] pcNext,
  output logic [31:0] pc,
  input wire logic flagWrEn,
  input wire logic [4:0] flagWrData,
  input wire logic statusWrEn,
  input wire logic [15:0] statusWrData,
  output logic [15:0] statusWord,
  output logic supervisor,
  output logic privFault,
  output logic sizeFault
);
  typedef enum logic {WR_COLLECT, WR_RESP} wrState_t;
  typedef enum logic {RD_IDLE, RD_DATA} rdState_t;

  logic rstMeta;
  logic rstN;
  wrState_t wrState;
  rdState_t rdState;
  logic awGot;
  logic wGot;
  logic [7:0] awAddrHeld;
  logic [31:0] wDataHeld;
  logic [3:0] wStrbHeld;
  logic [31:0] regQ [0:16];
  logic [4:0] flag_byte;
  logic [2:0] intMask;
  logic superBit;
  logic traceBit;

  // Reset released through two flops so every block leaves reset together
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  function automatic logic [4:0] physIdx(input logic [3:0] sel, input logic sup);
    if (sel == 4'hF && sup) begin
      physIdx = cpu_regs_pkg::SSP_IDX;
    end else begin
      physIdx = {1'b0, sel};
    end
  endfunction

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      old[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
    mergeStrb = old;
  endfunction

  // Core write port decode
  wire coreToPtr = coreWrSel[3];
  wire coreSizeBad = coreWrEn & coreToPtr & (coreWrSize == cpu_regs_pkg::SZ_BYTE);
  wire coreWrOk = coreWrEn & ~coreSizeBad;
  wire [4:0] coreWrIdx = physIdx(coreWrSel, superBit);

  // AXI write decode
  wire axiWrDo = (wrState == WR_COLLECT) & awGot & wGot;
  wire [5:0] axiWrWord = awAddrHeld[7:2];
  wire axiWrMapped = axiWrWord <= {1'b0, cpu_regs_pkg::STATUS_IDX};
  wire axiWrGo = axiWrDo & axiWrMapped;
  wire axiWrPc = axiWrGo & (axiWrWord[4:0] == cpu_regs_pkg::PC_IDX);
  wire axiWrStatus = axiWrGo & (axiWrWord[4:0] == cpu_regs_pkg::STATUS_IDX);
  wire [31:0] axiStatusFull = mergeStrb({16'h0000, statusWord}, wDataHeld, wStrbHeld);
  // Upper half of the status slot has no storage
  wire [15:0] axiStatusVal = axiStatusFull[15:0];

  genvar gi;
  generate
    for (gi = 0; gi < cpu_regs_pkg::NUM_REGS; gi++) begin : g_reg
      wire coreHit = coreWrOk & (coreWrIdx == 5'(gi));
      wire axiHit = axiWrGo & (axiWrWord[4:0] == 5'(gi));
      // Core wins when both touch one register in a cycle
      wire [1:0] cellSize = coreHit ? coreWrSize : cpu_regs_pkg::SZ_LONG;
      wire [31:0] cellData = coreHit ? coreWrData : mergeStrb(regQ[gi], wDataHeld, wStrbHeld);
      gpr_cell #(
        .SIGN_EXT(gi >= 8)
      ) u_cell (
        .clk_sys(clk_sys),
        .rstN(rstN),
        .wrEn(coreHit | axiHit),
        .wrSize(cellSize),
        .wrData(cellData),
        .q(regQ[gi])
      );
    end
  endgenerate

  // Operand read port: data regs sized, pointer regs word or long
  wire [31:0] rdRaw = regQ[physIdx(coreRdSel, superBit)];
  wire rdFromPtr = coreRdSel[3];
  wire [31:0] rdByte = {24'h000000, rdRaw[7:0]};
  wire [31:0] rdWordZ = {16'h0000, rdRaw[15:0]};
  wire [31:0] rdWordS = {{16{rdRaw[15]}}, rdRaw[15:0]};
  wire rdIsLong = coreRdSize == cpu_regs_pkg::SZ_LONG;
  wire rdIsByte = coreRdSize == cpu_regs_pkg::SZ_BYTE;
  wire [31:0] rdVal = rdIsLong ? rdRaw :
                      rdFromPtr ? rdWordS :
                      rdIsByte ? rdByte : rdWordZ;

  // Index port: any of sixteen, word index sign-extended
  wire [31:0] idxRaw = regQ[physIdx(idxSel, superBit)];
  wire [31:0] idxVal = idxLong ? idxRaw : {{16{idxRaw[15]}}, idxRaw[15:0]};

  // AXI read decode
  wire [5:0] axiRdWord = s_axi_araddr[7:2];
  wire axiRdMapped = axiRdWord <= {1'b0, cpu_regs_pkg::STATUS_IDX};
  wire axiRdGpr = axiRdWord < 6'(cpu_regs_pkg::NUM_REGS);
  wire axiRdPc = axiRdWord[4:0] == cpu_regs_pkg::PC_IDX;
  wire [31:0] axiRdVal = !axiRdMapped ? 32'h0000_0000 :
                         axiRdGpr ? regQ[axiRdWord[4:0]] :
                         axiRdPc ? pc : {16'h0000, statusWord};

  // Status word assembly; reserved positions read zero
  assign statusWord = {traceBit, 1'b0, superBit, 2'b00, intMask,
                       3'b000, flag_byte};
  assign supervisor = superBit;

  // Status write paths
  wire privWrOk = statusWrEn & superBit;
  wire privWrBad = statusWrEn & ~superBit;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      flag_byte <= cpu_regs_pkg::SR_RESET[cpu_regs_pkg::SR_C +: cpu_regs_pkg::SR_CCR_W];
      intMask <= cpu_regs_pkg::SR_RESET[cpu_regs_pkg::SR_MASK_LSB +: cpu_regs_pkg::SR_MASK_W];
      superBit <= cpu_regs_pkg::SR_RESET[cpu_regs_pkg::SR_S];
      traceBit <= cpu_regs_pkg::SR_RESET[cpu_regs_pkg::SR_T];
    end else if (privWrOk) begin
      flag_byte <= statusWrData[cpu_regs_pkg::SR_C +: cpu_regs_pkg::SR_CCR_W];
      intMask <= statusWrData[cpu_regs_pkg::SR_MASK_LSB +: cpu_regs_pkg::SR_MASK_W];
      superBit <= statusWrData[cpu_regs_pkg::SR_S];
      traceBit <= statusWrData[cpu_regs_pkg::SR_T];
    end else if (flagWrEn) begin
      // Flag byte stays writable from user level
      flag_byte <= flagWrData;
    end else if (axiWrStatus) begin
      flag_byte <= axiStatusVal[cpu_regs_pkg::SR_C +: cpu_regs_pkg::SR_CCR_W];
      intMask <= axiStatusVal[cpu_regs_pkg::SR_MASK_LSB +: cpu_regs_pkg::SR_MASK_W];
      superBit <= axiStatusVal[cpu_regs_pkg::SR_S];
      traceBit <= axiStatusVal[cpu_regs_pkg::SR_T];
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      pc <= cpu_regs_pkg::PC_RESET;
    end else if (pcLoad) begin
      pc <= pcNext;
    end else if (axiWrPc) begin
      pc <= mergeStrb(pc, wDataHeld, wStrbHeld);
    end
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      coreRdData <= 32'h0000_0000;
      idxData <= 32'h0000_0000;
      privFault <= 1'b0;
      sizeFault <= 1'b0;
    end else begin
      coreRdData <= rdVal;
      idxData <= idxVal;
      privFault <= privWrBad;
      sizeFault <= coreSizeBad;
    end
  end

  // AXI write channel: address and data taken in either order
  wire awHs = s_axi_awvalid & s_axi_awready;
  wire wHs = s_axi_wvalid & s_axi_wready;

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      wrState <= WR_COLLECT;
      awGot <= 1'b0;
      wGot <= 1'b0;
      awAddrHeld <= 8'h00;
      wDataHeld <= 32'h0000_0000;
      wStrbHeld <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cpu_regs_pkg::RESP_OKAY;
    end else begin
      case (wrState)
        WR_COLLECT: begin
          if (awHs) begin
            awGot <= 1'b1;
            awAddrHeld <= s_axi_awaddr;
          end
          if (wHs) begin
            wGot <= 1'b1;
            wDataHeld <= s_axi_wdata;
            wStrbHeld <= s_axi_wstrb;
          end
          s_axi_awready <= ~(awGot | awHs);
          s_axi_wready <= ~(wGot | wHs);
          if (awGot && wGot) begin
            wrState <= WR_RESP;
            awGot <= 1'b0;
            wGot <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= axiWrMapped ? cpu_regs_pkg::RESP_OKAY : cpu_regs_pkg::RESP_SLVERR;
          end
        end
        WR_RESP: begin
          if (s_axi_bready) begin
            wrState <= WR_COLLECT;
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
          end
        end
        default: wrState <= WR_COLLECT;
      endcase
    end
  end

  // AXI read channel: data sampled at the address handshake
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      rdState <= RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= cpu_regs_pkg::RESP_OKAY;
    end else begin
      case (rdState)
        RD_IDLE: begin
          s_axi_arready <= 1'b1;
          if (s_axi_arvalid && s_axi_arready) begin
            rdState <= RD_DATA;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= axiRdVal;
            s_axi_rresp <= axiRdMapped ? cpu_regs_pkg::RESP_OKAY : cpu_regs_pkg::RESP_SLVERR;
          end
        end
        RD_DATA: begin
          if (s_axi_rready) begin
            rdState <= RD_IDLE;
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
          end
        end
        default: rdState <= RD_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== core/cpu_regs_pkg.sv ====
// Constants shared by the architectural register file and its register cell
package cpu_regs_pkg;
  localparam int NUM_REGS = 17;
  localparam int IDX_W = 5;
  localparam logic [4:0] USP_IDX = 5'h0F;
  localparam logic [4:0] SSP_IDX = 5'h10;
  localparam logic [4:0] PC_IDX = 5'h11;
  localparam logic [4:0] STATUS_IDX = 5'h12;
  localparam logic [4:0] PTR0_IDX = 5'h08;

  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_DATA0 = 8'h00;
  localparam logic [7:0] OFS_PTR0 = 8'h20;
  localparam logic [7:0] OFS_USP = 8'h3C;
  localparam logic [7:0] OFS_SSP = 8'h40;
  localparam logic [7:0] OFS_PC = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;

  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;

  localparam int SR_C = 0;
  localparam int SR_V = 1;
  localparam int SR_Z = 2;
  localparam int SR_N = 3;
  localparam int SR_X = 4;
  localparam int SR_CCR_W = 5;
  localparam int SR_MASK_LSB = 8;
  localparam int SR_MASK_W = 3;
  localparam int SR_S = 13;
  localparam int SR_T = 15;
  localparam logic [15:0] SR_RESERVED = 16'h58E0;
  localparam logic [15:0] SR_RESET = 16'h2700;
  localparam logic [31:0] GPR_RESET = 32'h0000_0000;
  localparam logic [31:0] PC_RESET = 32'h0000_0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== core/gpr_cell.sv ====
// One 32-bit general register with byte, word and long-word write sizing
`timescale 1ns/100ps
`default_nettype none
module gpr_cell #(
  parameter bit SIGN_EXT = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rstN,
  input wire logic wrEn,
  input wire logic [1:0] wrSize,
  input wire logic [31:0] wrData,
  output logic [31:0] q
);
  logic [31:0] next_q;

  always_comb begin
    next_q = q;
    case (wrSize)
      cpu_regs_pkg::SZ_BYTE: next_q = {q[31:8], wrData[7:0]};
      cpu_regs_pkg::SZ_WORD: begin
        // Pointer registers always take the whole 32 bits
        if (SIGN_EXT) begin
          next_q = {{16{wrData[15]}}, wrData[15:0]};
        end else begin
          next_q = {q[31:16], wrData[15:0]};
        end
      end
      default: next_q = wrData;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      q <= cpu_regs_pkg::GPR_RESET;
    end else if (wrEn) begin
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

// ==== test/cpu_register_model_assertions.sv ====
// Port-level checks on the architectural register model
`timescale 1ns/100ps
`default_nettype none
module cpu_register_model_assertions (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic coreWrEn,
  input wire logic [3:0] coreWrSel,
  input wire logic [1:0] coreWrSize,
  input wire logic [3:0] coreRdSel,
  input wire logic [1:0] coreRdSize,
  input wire logic [31:0] coreRdData,
  input wire logic idxLong,
  input wire logic [31:0] idxData,
  input wire logic pcLoad,
  input wire logic [31:0] pcNext,
  input wire logic [31:0] pc,
  input wire logic flagWrEn,
  input wire logic [4:0] flagWrData,
  input wire logic statusWrEn,
  input wire logic [15:0] statusWrData,
  input wire logic [15:0] statusWord,
  input wire logic supervisor,
  input wire logic privFault,
  input wire logic sizeFault
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  sequence rdTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence rdAnswer;
    s_axi_rvalid && !s_axi_arready;
  endsequence
  read_answer_a: assert property (rdTaken |=> rdAnswer)
    else $error("read answer missing");
  size_fault_a: assert property (coreWrEn |=> sizeFault == $past(coreWrSel[3] && coreWrSize == 2'h0))
    else $error("size fault wrong");
  priv_fault_a: assert property (statusWrEn |=> privFault == $past(!supervisor))
    else $error("privilege fault wrong");
  status_write_a: assert property (statusWrEn && supervisor |=> statusWord == ($past(statusWrData) & 16'hA71F))
    else $error("status write lost");
  flag_write_a: assert property (flagWrEn && !(statusWrEn && supervisor) |=> statusWord[4:0] == $past(flagWrData))
    else $error("flag write lost");
  super_bit_a: assert property (supervisor == statusWord[13])
    else $error("supervisor output differs");
  reserved_zero_a: assert property ((statusWord & 16'h58E0) == 16'h0000)
    else $error("reserved status bit set");
  pc_load_a: assert property (pcLoad |=> pc == $past(pcNext))
    else $error("pc load lost");
  byte_read_a: assert property (!coreRdSel[3] && coreRdSize == 2'h0 |=> coreRdData[31:8] == 24'h000000)
    else $error("byte read not zero extended");
  index_word_a: assert property (!idxLong |=> idxData[31:16] == {16{idxData[15]}})
    else $error("word index not sign extended");
endmodule
bind cpu_register_model cpu_register_model_assertions chk_u (.*);
`default_nettype wire

// ==== test/tb_cpu_register_model.sv ====
// Self-checking bench for the architectural register model
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_register_model;
  logic clk_sys = 1'h0;
  logic rst_b;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, coreWrData, coreRdData, idxData, pcNext, pc, seed, r;
  logic [3:0] s_axi_wstrb, coreWrSel, coreRdSel, idxSel;
  logic [1:0] s_axi_bresp, s_axi_rresp, coreWrSize, coreRdSize;
  logic [4:0] flagWrData;
  logic [15:0] statusWrData, statusWord;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, coreWrEn, idxLong, pcLoad;
  logic flagWrEn, statusWrEn, supervisor, privFault, sizeFault;
  // Slots 0-16 registers, 17 pc, 18 status
  logic [31:0] rm [0:18];
  int miscompares = 0;
  int totalChecks = 0;
  int cyc = 0;

  cpu_register_model dut_u (.*);

  always #20 clk_sys = ~clk_sys;

  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [31:0] sx(input logic [31:0] v);
    return {{16{v[15]}}, v[15:0]};
  endfunction
  // Select 15 follows the supervisor bit
  function automatic int slot(input logic [3:0] s);
    return (s == 4'hF && rm[18][13]) ? 16 : int'(s);
  endfunction
  function automatic logic [31:0] nv(input logic [31:0] o, input logic [3:0] s, input logic [1:0] z,
                                     input logic [31:0] d);
    if (s[3]) return z == cpu_regs_pkg::SZ_WORD ? sx(d) : d;
    if (z == cpu_regs_pkg::SZ_BYTE) return {o[31:8], d[7:0]};
    if (z == cpu_regs_pkg::SZ_WORD) return {o[31:16], d[15:0]};
    return d;
  endfunction
  function automatic logic [31:0] rdExp(input logic [3:0] s, input logic [1:0] z);
    if (z == cpu_regs_pkg::SZ_LONG) return rm[slot(s)];
    if (s[3]) return sx(rm[slot(s)]);
    return z == cpu_regs_pkg::SZ_BYTE ? {24'h0, rm[s][7:0]} : {16'h0, rm[s][15:0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tallyAndFinish;
    if (miscompares == 0 && totalChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic axw(input int i, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] v;
    @(posedge clk_sys);
    s_axi_awaddr <= 8'(i * 4);
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, i < 19 ? cpu_regs_pkg::RESP_OKAY : cpu_regs_pkg::RESP_SLVERR});
    if (i < 19) begin
      v = rm[i];
      for (int b = 0; b < 4; b++) if (s[b]) v[8*b +: 8] = d[8*b +: 8];
      rm[i] = (i == 18) ? (v & {16'h0, ~cpu_regs_pkg::SR_RESERVED}) : v;
    end
  endtask
  task automatic axr(input int i);
    @(posedge clk_sys);
    s_axi_araddr <= 8'(i * 4);
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, i < 19 ? rm[i] : 32'h0);
    chk({30'h0, s_axi_rresp}, {30'h0, i < 19 ? cpu_regs_pkg::RESP_OKAY : cpu_regs_pkg::RESP_SLVERR});
  endtask
  task automatic verifyAll;
    for (int i = 0; i < 20; i++) axr(i);
    chk({31'h0, supervisor}, {31'h0, rm[18][13]});
    chk({16'h0, statusWord}, rm[18]);
  endtask

  task automatic cw(input logic [3:0] s, input logic [1:0] z, input logic [31:0] d);
    logic bad;
    bad = s[3] && z == cpu_regs_pkg::SZ_BYTE;
    @(posedge clk_sys);
    coreWrEn <= 1'h1;
    coreWrSel <= s;
    coreWrSize <= z;
    coreWrData <= d;
    @(posedge clk_sys);
    coreWrEn <= 1'h0;
    #1 chk({31'h0, sizeFault}, {31'h0, bad});
    if (!bad) rm[slot(s)] = nv(rm[slot(s)], s, z, d);
  endtask
  task automatic sw(input logic [15:0] d);
    logic bad;
    bad = !rm[18][13];
    @(posedge clk_sys);
    statusWrEn <= 1'h1;
    statusWrData <= d;
    @(posedge clk_sys);
    statusWrEn <= 1'h0;
    #1 chk({31'h0, privFault}, {31'h0, bad});
    if (!bad) rm[18] = {16'h0, d & ~cpu_regs_pkg::SR_RESERVED};
  endtask
  task automatic misc(input logic [4:0] f, input logic [31:0] p);
    @(posedge clk_sys);
    flagWrEn <= 1'h1;
    flagWrData <= f;
    pcLoad <= 1'h1;
    pcNext <= p;
    @(posedge clk_sys);
    flagWrEn <= 1'h0;
    pcLoad <= 1'h0;
    rm[18][4:0] = f;
    rm[17] = p;
  endtask
  task automatic rd(input logic [3:0] s, input logic [1:0] z);
    @(posedge clk_sys);
    coreRdSel <= s;
    coreRdSize <= z;
    idxSel <= s;
    idxLong <= z[1];
    @(posedge clk_sys);
    #1 chk(coreRdData, rdExp(s, z));
    chk(idxData, z[1] ? rm[slot(s)] : sx(rm[slot(s)]));
  endtask

  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, coreWrData, pcNext, s_axi_wstrb, coreWrSel, coreRdSel} = '0;
    {idxSel, coreWrSize, coreRdSize, flagWrData, statusWrData, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, coreWrEn, idxLong, pcLoad, flagWrEn, statusWrEn, rst_b} = '0;
    seed = 32'h8DC9FAC3;
    for (int i = 0; i < 17; i++) rm[i] = cpu_regs_pkg::GPR_RESET;
    rm[17] = cpu_regs_pkg::PC_RESET;
    rm[18] = {16'h0, cpu_regs_pkg::SR_RESET};
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'h1;
    repeat (3) @(posedge clk_sys);
    verifyAll;
    axw(18, 32'hFFFFFFFF, 4'h3);
    cw(4'hF, cpu_regs_pkg::SZ_LONG, 32'h5A5A0001);
    sw(16'h0704);
    sw(16'h2000);
    cw(4'hF, cpu_regs_pkg::SZ_WORD, 32'h00008001);
    cw(4'h8, cpu_regs_pkg::SZ_BYTE, 32'h000000FF);
    verifyAll;
    for (int n = 0; n < 80; n++) begin
      r = lfsr();
      cw(r[3:0], r[5:4], lfsr());
      if (r[8:6] == 3'h0) sw(r[31:16]);
      if (r[8:6] == 3'h1) misc(r[20:16], lfsr());
      if (r[8:6] == 3'h2) axw(int'(r[13:9]) % 20, lfsr(), r[17:14]);
      if (r[8:6] == 3'h3) rd(r[3:0], 2'(r[10:9] % 3));
    end
    verifyAll;
    for (int s = 0; s < 16; s++) for (int z = 0; z < 3; z++) rd(4'(s), 2'(z));
    tallyAndFinish;
  end

  // Cuts a hang short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      tallyAndFinish;
    end
  end
endmodule
`default_nettype wire
